// ### rtl/adc_pair_trigger_control.v
// Trigger, pending and interrupt control for the channel four/five pair.
// Assumes a converter core that grants and reports done with one-cycle pulses.
`timescale 1ns/1ps
`include "pair_trig_consts.vh"

// Overview of operation
// - Interrupt raised on pair completion only when enable bit is set.
// - Pending bit sets on selected trigger, clears on completion.
// - Writing soft trigger bit starts pair conversion when selected.
// - Soft trigger bit self-clears once pending sets.
// - Five-bit selector picks the start source; zero disables.
// - Code 1 individual software, code 2 global software trigger.
// - Code 3 selects the PWM special event trigger.
// - Codes 4, 5, 7 select PWM 1, 2, 4 primary triggers.
// - Code 0C starts on first timer period match.
// - Codes 0E, 0F, 11 select PWM 1, 2, 4 secondary triggers.
// - Codes 17, 18, 1A select PWM 1, 2, 4 current-limit triggers.
// - Code 1F starts on second timer period match.
// - Busy converter defers the pair conversion until resources free.
module adc_pair_trigger_control (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // Register port
  input wire [3:0] addr,
  input wire [15:0] wdata,
  input wire wr,
  input wire rd,
  output reg [15:0] rdata,
  // Trigger sources
  input wire global_soft_trig,
  input wire pwm_special_trig,
  input wire [2:0] pwm_primary_trig,
  input wire [2:0] pwm_secondary_trig,
  input wire [2:0] pwm_limit_trig,
  input wire first_timer_match,
  input wire second_timer_match,
  // Converter core
  input wire conv_busy,
  input wire conv_done,
  output wire conv_request,
  // Interrupts
  output wire pair_irq,
  output wire irq
);

  localparam ST_IDLE = 3'b001;
  localparam ST_WAIT = 3'b010;
  localparam ST_CONV = 3'b100;

  reg pair_irq_enable;
  reg pair_pending_flag;
  reg pair_soft_trigger;
  reg [4:0] pair_trigger_select;
  reg [2:0] state;
  reg [2:0] next_state;
  reg [1:0] irq_status;
  reg [1:0] irq_mask;
  reg pair_irq_q;
  wire trig_event;
  wire done_pair;
  wire ctrl_wr;
  wire status_rd;

  function is_addr;
    input [3:0] a;
    input [3:0] target;
    begin
      is_addr = (a == target);
    end
  endfunction

  assign ctrl_wr = wr & is_addr(addr, `ADDR_PAIR_CTRL);
  assign status_rd = rd & is_addr(addr, `ADDR_IRQ_STATUS);

  trigger_select_mux u_mux (
    .clk(clk),
    .rstn(rstn),
    .trigger_select_field(pair_trigger_select),
    .soft_trig(pair_soft_trigger),
    .global_soft_trig(global_soft_trig),
    .pwm_special_trig(pwm_special_trig),
    .pwm_primary_trig(pwm_primary_trig),
    .pwm_secondary_trig(pwm_secondary_trig),
    .pwm_limit_trig(pwm_limit_trig),
    .first_timer_match(first_timer_match),
    .second_timer_match(second_timer_match),
    .trig_event(trig_event)
  );

  assign done_pair = (state == ST_CONV) & conv_done;

  always @* begin
    case (state)
      ST_IDLE: next_state = trig_event ? ST_WAIT : ST_IDLE;
      ST_WAIT: next_state = conv_busy ? ST_WAIT : ST_CONV;
      ST_CONV: next_state = conv_done ? ST_IDLE : ST_CONV;
      default: next_state = ST_IDLE;
    endcase
  end

  // Request pulses for one cycle, in ST_WAIT while busy is low; ST_CONV follows without waiting for busy
  assign conv_request = (state == ST_WAIT) & ~conv_busy;

  always @(posedge clk) begin
    if (!rstn) begin
      state <= ST_IDLE;
      pair_irq_enable <= 1'b0;
      pair_trigger_select <= `TRG_OFF;
      pair_soft_trigger <= 1'b0;
      pair_pending_flag <= 1'b0;
      pair_irq_q <= 1'b0;
    end else begin
      state <= next_state;
      if (ctrl_wr) begin
        pair_irq_enable <= wdata[`BIT_IRQ_ENABLE];
        pair_trigger_select <= wdata[`SEL_MSB:`SEL_LSB];
      end
      if (trig_event | pair_pending_flag) begin
        pair_soft_trigger <= 1'b0;
      end else if (ctrl_wr && wdata[`BIT_SOFT_TRIG]) begin
        pair_soft_trigger <= 1'b1;
      end
      if (trig_event && state == ST_IDLE) begin
        pair_pending_flag <= 1'b1;
      end else if (done_pair) begin
        pair_pending_flag <= 1'b0;
      end
      pair_irq_q <= done_pair & pair_irq_enable;
    end
  end

  assign pair_irq = pair_irq_q;

  // Sticky status, set wins over read clear
  always @(posedge clk) begin
    if (!rstn) begin
      irq_status <= 2'h0;
      irq_mask <= `RST_IRQ_MASK;
    end else begin
      irq_status <= (status_rd ? 2'h0 : irq_status) |
                    {trig_event, done_pair & pair_irq_enable};
      if (wr && is_addr(addr, `ADDR_IRQ_MASK)) begin
        irq_mask <= wdata[1:0];
      end
    end
  end

  assign irq = |(irq_status & irq_mask);

  always @(posedge clk) begin
    if (!rstn) begin
      rdata <= 16'h0000;
    end else if (rd) begin
      case (addr)
        `ADDR_PAIR_CTRL: rdata <= {8'h00, pair_irq_enable, pair_pending_flag,
                                   pair_soft_trigger, pair_trigger_select};
        `ADDR_IRQ_STATUS: rdata <= {14'h0000, irq_status};
        `ADDR_IRQ_MASK: rdata <= {14'h0000, irq_mask};
        default: rdata <= 16'h0000;
      endcase
    end else begin
      rdata <= 16'h0000;
    end
  end

endmodule // adc_pair_trigger_control

// ### rtl/pair_trig_consts.vh
// Constants for the conversion pair trigger control block.
// Assumes inclusion by bare name from rtl/.
`ifndef PAIR_TRIG_CONSTS_VH
`define PAIR_TRIG_CONSTS_VH

// Register offsets (word addresses on the plain port)
`define ADDR_PAIR_CTRL 4'h0
`define ADDR_IRQ_STATUS 4'h1
`define ADDR_IRQ_MASK 4'h2

// Field positions in the pair control register
`define BIT_IRQ_ENABLE 7
`define BIT_PENDING 6
`define BIT_SOFT_TRIG 5
`define SEL_MSB 4
`define SEL_LSB 0

// Reset values
`define RST_PAIR_CTRL 16'h0000
`define RST_IRQ_MASK 2'h0

// Trigger source codes
`define TRG_OFF 5'h00
`define TRG_INDIV_SW 5'h01
`define TRG_GLOBAL_SW 5'h02
`define TRG_SPECIAL 5'h03
`define TRG_PWM1_PRI 5'h04
`define TRG_PWM2_PRI 5'h05
`define TRG_PWM4_PRI 5'h07
`define TRG_TMR1 5'h0C
`define TRG_PWM1_SEC 5'h0E
`define TRG_PWM2_SEC 5'h0F
`define TRG_PWM4_SEC 5'h11
`define TRG_PWM1_CL 5'h17
`define TRG_PWM2_CL 5'h18
`define TRG_PWM4_CL 5'h1A
`define TRG_TMR2 5'h1F

// Interrupt status bits
`define IST_DONE 0
`define IST_TRIG 1

`endif

// ### rtl/trigger_select_mux.v
// Trigger source selector with edge detection.
// Assumes all trigger inputs are synchronous levels or pulses.
`timescale 1ns/1ps
`include "pair_trig_consts.vh"

module trigger_select_mux (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // Selection
  input wire [4:0] trigger_select_field,
  // Sources
  input wire soft_trig,
  input wire global_soft_trig,
  input wire pwm_special_trig,
  input wire [2:0] pwm_primary_trig,
  input wire [2:0] pwm_secondary_trig,
  input wire [2:0] pwm_limit_trig,
  input wire first_timer_match,
  input wire second_timer_match,
  // Result
  output wire trig_event
);

  reg sel_level;
  reg sel_prev;

  always @* begin
    case (trigger_select_field)
      `TRG_INDIV_SW: sel_level = soft_trig;
      `TRG_GLOBAL_SW: sel_level = global_soft_trig;
      `TRG_SPECIAL: sel_level = pwm_special_trig;
      `TRG_PWM1_PRI: sel_level = pwm_primary_trig[0];
      `TRG_PWM2_PRI: sel_level = pwm_primary_trig[1];
      `TRG_PWM4_PRI: sel_level = pwm_primary_trig[2];
      `TRG_TMR1: sel_level = first_timer_match;
      `TRG_PWM1_SEC: sel_level = pwm_secondary_trig[0];
      `TRG_PWM2_SEC: sel_level = pwm_secondary_trig[1];
      `TRG_PWM4_SEC: sel_level = pwm_secondary_trig[2];
      `TRG_PWM1_CL: sel_level = pwm_limit_trig[0];
      `TRG_PWM2_CL: sel_level = pwm_limit_trig[1];
      `TRG_PWM4_CL: sel_level = pwm_limit_trig[2];
      `TRG_TMR2: sel_level = second_timer_match;
      default: sel_level = 1'b0;
    endcase
  end

  always @(posedge clk) begin
    if (!rstn) begin
      sel_prev <= 1'b0;
    end else begin
      sel_prev <= sel_level;
    end
  end

  assign trig_event = sel_level & ~sel_prev;

endmodule // trigger_select_mux

// ### verification/conv_core_model.sv
// Converter core model: takes a request, stays busy, then pulses done.
// Assumes requests come only while busy is low.
`timescale 1ns/1ps
module conv_core_model (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // Pair side
  input wire conv_request,
  output wire conv_busy,
  output reg conv_done,
  // Length and other traffic
  input wire [3:0] conv_len,
  input wire other_busy
);
  reg run;
  reg [3:0] cnt;
  // Other channels can hold the shared resources
  assign conv_busy = run | other_busy;
  always @(posedge clk) begin
    conv_done <= 1'b0;
    if (!rstn) begin
      run <= 1'b0;
      cnt <= 4'h0;
    end else if (run) begin
      cnt <= cnt - 4'h1;
      if (cnt == 4'h0) begin
        run <= 1'b0;
        conv_done <= 1'b1;
      end
    end else if (conv_request) begin
      run <= 1'b1;
      cnt <= conv_len;
    end
  end
endmodule // conv_core_model

// ### verification/pair_trig_props.sv
// Port checker for the pair trigger block.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`include "pair_trig_consts.vh"
module pair_trig_props (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // Register port
  input wire [3:0] addr,
  input wire [15:0] wdata,
  input wire wr,
  input wire rd,
  input wire [15:0] rdata,
  // Core and interrupts
  input wire conv_busy,
  input wire conv_done,
  input wire conv_request,
  input wire pair_irq,
  input wire irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_rd_idle; !rd |=> rdata == 16'h0000; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("rdata not idle");
  property p_hi_zero; rd |=> rdata[15:8] == 8'h00; endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("upper byte set");
  property p_req_idle; conv_request |-> !conv_busy; endproperty
  a_req_idle: assert property (p_req_idle) else $error("request while busy");
  property p_req_one; conv_request |=> !conv_request; endproperty
  a_req_one: assert property (p_req_one) else $error("request repeated");
  property p_irq_cause; pair_irq |-> $past(conv_done); endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without done");
  property p_irq_pulse; pair_irq |=> !pair_irq; endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq too long");
  property p_done_quiet; conv_done |=> !conv_request; endproperty
  a_done_quiet: assert property (p_done_quiet) else $error("request after done");
  property p_mask_off; wr && addr == `ADDR_IRQ_MASK && wdata[1:0] == 2'h0 |=> !irq; endproperty
  a_mask_off: assert property (p_mask_off) else $error("irq while masked");
endmodule // pair_trig_props
bind adc_pair_trigger_control pair_trig_props pair_trig_props_i (.clk(clk), .rstn(rstn),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .conv_busy(conv_busy),
  .conv_done(conv_done), .conv_request(conv_request), .pair_irq(pair_irq), .irq(irq));

// ### verification/testbench.sv
// Self-checking bench for the pair trigger block with a core model.
// Assumes the register map and codes of pair_trig_consts.vh.
`timescale 1ns/1ps
`include "pair_trig_consts.vh"
module testbench;
  reg clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, obusy = 1'b0;
  reg [3:0] addr = 4'h0, len = 4'h3;
  reg [15:0] wdata = 16'h0000;
  reg [12:0] src = 13'h0000;
  reg [31:0] lfsr = 32'h0B10;
  wire [15:0] rdata;
  wire busy, done, req, pair_irq, irq;
  integer mismatches = 0, check_count = 0, irq_cnt = 0, k, n, i;
  localparam [64:0] codes = {5'h1F, 5'h1A, 5'h18, 5'h17, 5'h11, 5'h0F, 5'h0E, 5'h0C,
    5'h07, 5'h05, 5'h04, 5'h03, 5'h02};
  always #20 clk = ~clk;
  always @(posedge clk) if (pair_irq === 1'b1) irq_cnt <= irq_cnt + 1;
  adc_pair_trigger_control adc_pair_trigger_control_i (.clk(clk), .rstn(rstn), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .global_soft_trig(src[0]),
    .pwm_special_trig(src[1]), .pwm_primary_trig(src[4:2]), .pwm_secondary_trig(src[8:6]),
    .pwm_limit_trig(src[11:9]), .first_timer_match(src[5]), .second_timer_match(src[12]),
    .conv_busy(busy), .conv_done(done), .conv_request(req), .pair_irq(pair_irq), .irq(irq));
  conv_core_model conv_core_model_i (.clk(clk), .rstn(rstn), .conv_request(req),
    .conv_busy(busy), .conv_done(done), .conv_len(len), .other_busy(obusy));
  function [31:0] next_lfsr(input [31:0] v);
    next_lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // One-hot source for a trigger code, zero for codes 0, 1 and reserved codes
  function [12:0] sel_bit(input [4:0] c);
    integer j;
    begin
      sel_bit = 13'h0000;
      for (j = 0; j < 13; j = j + 1)
        if (codes[5*j +: 5] == c) sel_bit[j] = 1'b1;
    end
  endfunction
  task check(input [15:0] exp, input [15:0] got, input [8*8-1:0] what);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("ERROR %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task wr_reg(input [3:0] a, input [15:0] d);
    begin
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
    end
  endtask
  task rd_chk(input [3:0] a, input [15:0] exp, input [8*8-1:0] what);
    begin
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 check(exp, rdata, what);
      @(posedge clk);
    end
  endtask
  task wait_done;
    begin
      for (n = 0; n < 60 && done !== 1'b1; n = n + 1) @(posedge clk);
      repeat (2) @(posedge clk);
    end
  endtask
  task test_done;
    begin
      if (mismatches == 0 && check_count > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd_chk(`ADDR_PAIR_CTRL, 16'h0000, "ctrl");
    rd_chk(4'hF, 16'h0000, "unmapped");
    wr_reg(`ADDR_IRQ_MASK, 16'h0003);
    for (k = 0; k < 32; k = k + 1) begin
      lfsr = next_lfsr(lfsr);
      len <= lfsr[3:0];
      obusy <= lfsr[4];
      wr_reg(`ADDR_PAIR_CTRL, {8'h00, 3'b100, k[4:0]});
      i = irq_cnt;
      src <= lfsr[20:8] & ~sel_bit(k[4:0]);
      @(posedge clk);
      src <= (sel_bit(k[4:0]) == 13'h0000) ? 13'h1FFF : sel_bit(k[4:0]);
      repeat (4) @(posedge clk);
      src <= 13'h0000;
      obusy <= 1'b0;
      wait_done;
      n = irq_cnt - i;
      check({15'h0000, |sel_bit(k[4:0])}, n[15:0], "events");
    end
    len <= 4'hF;
    i = irq_cnt;
    // Select the software source first, then fire the trigger bit
    wr_reg(`ADDR_PAIR_CTRL, 16'h0081);
    wr_reg(`ADDR_PAIR_CTRL, 16'h00A1);
    rd_chk(`ADDR_PAIR_CTRL, 16'h00C1, "pending");
    wait_done;
    n = irq_cnt - i;
    check(16'h0001, n[15:0], "soft");
    rd_chk(`ADDR_PAIR_CTRL, 16'h0081, "done");
    rd_chk(`ADDR_IRQ_STATUS, 16'h0003, "status");
    check(16'h0000, {15'h0000, irq}, "irq");
    wr_reg(`ADDR_PAIR_CTRL, 16'h0021);
    wait_done;
    n = irq_cnt - i;
    check(16'h0001, n[15:0], "no_en");
    wr_reg(`ADDR_IRQ_MASK, 16'h0000);
    check(16'h0000, {15'h0000, irq}, "masked");
    wr_reg(`ADDR_IRQ_MASK, 16'h0002);
    check(16'h0001, {15'h0000, irq}, "unmask");
    rd_chk(`ADDR_IRQ_STATUS, 16'h0002, "status");
    check(16'h0000, {15'h0000, irq}, "cleared");
    test_done;
  end
  initial begin
    #400000;
    mismatches = mismatches + 1;
    test_done;
  end
endmodule // testbench
